// File: acwd_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "acwd_defines.vh"
module acwd_decoder (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // Fieldbus write port
    input  wire        bus_wr,
    input  wire [15:0] bus_wdata,
    // Part program byte inputs
    input  wire        prog_lo_wr,
    input  wire [7:0]  prog_lo_data,
    input  wire        prog_hi_wr,
    input  wire [7:0]  prog_hi_data,
    // Drive context
    input  wire [2:0]  op_mode,
    input  wire        fault_event,
    input  wire        fault_reaction_done,
    input  wire        init_done,
    input  wire        stop_done,
    // Register readback and state
    output reg  [15:0] axis_command_word,
    output reg  [6:0]  axis_state,
    output reg         power_stage_en,
    output reg         setpoint_track_en,
    // Axis command strobes
    output reg         cmd_shutdown,
    output reg         cmd_switch_on,
    output reg         cmd_enable_op,
    output reg         cmd_disable_op,
    output reg         cmd_quick_stop,
    output reg         cmd_disable_volt,
    output reg         cmd_fault_reset,
    // Mode dependent commands
    output reg         pp_new_setpoint,
    output reg         pp_change_now,
    output reg         pp_relative,
    output reg         homing_start,
    output reg         gear_sync,
    output reg         interp_enable,
    // Part program commands
    output reg         program_run_request,
    output reg         program_clear_request,
    output reg         prog_stop,
    output reg         prog_resume
);

////////////////////////////////////////////////////////////////////////
localparam [6:0] ST_NOT_READY = 7'h01;
localparam [6:0] ST_SW_DIS    = 7'h02;
localparam [6:0] ST_READY     = 7'h04;
localparam [6:0] ST_SW_ON     = 7'h08;
localparam [6:0] ST_OP_EN     = 7'h10;
localparam [6:0] ST_QSTOP     = 7'h20;
localparam [6:0] ST_FAULT_R   = 7'h40;
localparam [6:0] ST_FAULT     = 7'h00;

////////////////////////////////////////////////////////////////////////
reg         fr_prev_r;
reg  [15:0] word_nxt;

// Bus write takes the whole word; program byte writes merge
always @* begin
    word_nxt = axis_command_word;
    if (bus_wr) begin
        word_nxt = bus_wdata;
    end
    if (prog_lo_wr) begin
        word_nxt[7:0] = prog_lo_data;                      // [RULE18]
    end
    if (prog_hi_wr) begin
        word_nxt[15:8] = prog_hi_data;                     // [RULE18]
    end
end

always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        axis_command_word <= `ACWD_WORD_RESET;
        fr_prev_r         <= 1'b0;
    end else begin
        axis_command_word <= word_nxt;
        fr_prev_r         <= axis_command_word[`ACWD_BIT_FRESET];
    end
end

////////////////////////////////////////////////////////////////////////
wire [15:0] w = axis_command_word;
wire b0 = w[`ACWD_BIT_SWITCH_ON];                          // [RULE1]
wire b1 = w[`ACWD_BIT_VOLT];
wire b2 = w[`ACWD_BIT_QSTOP];
wire b3 = w[`ACWD_BIT_ENABLE];
wire dv_m = !b1;                                           // [RULE12]
wire qs_m = !b2 && b1;                                     // [RULE11]
wire sd_m = b2 && b1 && !b0;                               // [RULE7]
wire so_m = b2 && b1 && b0;                                // [RULE8]
wire eo_m = so_m && b3;                                    // [RULE9]
wire do_m = so_m && !b3;                                   // [RULE10]
// Level stays high; only the edge resets a fault
wire fr_m = w[`ACWD_BIT_FRESET] && !fr_prev_r;             // [RULE13]

// Priority: disable voltage, then quick stop, then the rest
wire dv_p = dv_m;                                          // [RULE21]
wire qs_p = qs_m && !dv_m;                                 // [RULE21]

reg [6:0] st_nxt;
always @* begin
    st_nxt = axis_state;
    if (fault_event) begin
        st_nxt = ST_FAULT_R;                               // [RULE19]
    end else begin
        // Commands not legal for the state leave it alone
        case (axis_state)                                  // [RULE22]
            ST_NOT_READY: begin
                if (init_done) st_nxt = ST_SW_DIS;
            end
            ST_SW_DIS: begin
                if (sd_m) st_nxt = ST_READY;
            end
            ST_READY: begin
                if (dv_p || qs_p) st_nxt = ST_SW_DIS;
                else if (so_m) st_nxt = ST_SW_ON;
            end
            ST_SW_ON: begin
                if (dv_p || qs_p) st_nxt = ST_SW_DIS;
                else if (sd_m) st_nxt = ST_READY;
                else if (eo_m) st_nxt = ST_OP_EN;
            end
            ST_OP_EN: begin
                if (dv_p) st_nxt = ST_SW_DIS;
                else if (qs_p) st_nxt = ST_QSTOP;
                else if (sd_m) st_nxt = ST_READY;
                else if (do_m) st_nxt = ST_SW_ON;
            end
            ST_QSTOP: begin
                if (dv_p || stop_done) st_nxt = ST_SW_DIS;
                else if (eo_m) st_nxt = ST_OP_EN;
            end
            ST_FAULT_R: begin
                if (fault_reaction_done) st_nxt = ST_FAULT;
            end
            ST_FAULT: begin
                if (fr_m) st_nxt = ST_SW_DIS;
            end
            default: st_nxt = ST_NOT_READY;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
wire m_pp = op_mode == `ACWD_MODE_PROFILE;
wire m_hm = op_mode == `ACWD_MODE_HOMING;
wire m_eg = op_mode == `ACWD_MODE_GEARING;
wire m_ip = op_mode == `ACWD_MODE_INTERP;

always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        axis_state            <= ST_NOT_READY;
        power_stage_en        <= 1'b0;
        setpoint_track_en     <= 1'b0;
        cmd_shutdown          <= 1'b0;
        cmd_switch_on         <= 1'b0;
        cmd_enable_op         <= 1'b0;
        cmd_disable_op        <= 1'b0;
        cmd_quick_stop        <= 1'b0;
        cmd_disable_volt      <= 1'b0;
        cmd_fault_reset       <= 1'b0;
        pp_new_setpoint       <= 1'b0;
        pp_change_now         <= 1'b0;
        pp_relative           <= 1'b0;
        homing_start          <= 1'b0;
        gear_sync             <= 1'b0;
        interp_enable         <= 1'b0;
        program_run_request   <= 1'b0;
        program_clear_request <= 1'b0;
        prog_stop             <= 1'b0;
        prog_resume           <= 1'b0;
    end else begin
        axis_state        <= st_nxt;
        // Power stage on in switched on, op enabled, quick stop
        power_stage_en    <= (st_nxt == ST_SW_ON) || (st_nxt == ST_OP_EN)
                             || (st_nxt == ST_QSTOP);      // [RULE20]
        setpoint_track_en <= st_nxt == ST_OP_EN;           // [RULE20]
        cmd_disable_volt  <= dv_p;                         // [RULE21]
        cmd_quick_stop    <= qs_p;                         // [RULE21]
        cmd_shutdown      <= sd_m;
        cmd_switch_on     <= so_m;
        cmd_enable_op     <= eo_m;
        cmd_disable_op    <= do_m;
        cmd_fault_reset   <= fr_m;                         // [RULE13]
        // Other modes see zeros here
        pp_new_setpoint   <= m_pp && w[`ACWD_BIT_MODE0];   // [RULE3] [RULE6]
        pp_change_now     <= m_pp && w[`ACWD_BIT_MODE1];   // [RULE3]
        pp_relative       <= m_pp && !w[`ACWD_BIT_MODE2];  // [RULE3]
        homing_start      <= m_hm && w[`ACWD_BIT_MODE0];   // [RULE4]
        gear_sync         <= m_eg && w[`ACWD_BIT_MODE0];   // [RULE5]
        interp_enable     <= m_ip && w[`ACWD_BIT_MODE0];   // [RULE5]
        program_run_request   <= w[`ACWD_BIT_RUN];         // [RULE2] [RULE17]
        program_clear_request <= w[`ACWD_BIT_CLEAR]
                                 && !w[`ACWD_BIT_RUN];     // [RULE2] [RULE16]
        prog_stop   <= !w[`ACWD_BIT_CLEAR] && !w[`ACWD_BIT_RUN];  // [RULE14]
        prog_resume <= !w[`ACWD_BIT_CLEAR] && w[`ACWD_BIT_RUN];   // [RULE15]
    end
end

endmodule
`default_nettype wire

// File: acwd_defines.vh
// What this block does
// [RULE1] Low byte bits: on, voltage, stop, enable, reset
// [RULE2] Bit 14 run, bit 15 clear request
// [RULE3] Profile position: setpoint, immediate change, abs/rel
// [RULE4] Homing mode: bit 4 starts homing run
// [RULE5] Bit 4: gearing sync, interpolation enable
// [RULE6] Other modes ignore bits 4 to 6
// [RULE7] Shut down: bits 2,1 set, bit 0 clear
// [RULE8] Switch on: bits 2,1,0 set
// [RULE9] Enable operation: bits 3..0 all set
// [RULE10] Disable operation: bit 3 clear, 2..0 set
// [RULE11] Quick stop: bit 2 clear, bit 1 set
// [RULE12] Disable voltage: bit 1 clear
// [RULE13] Fault reset on bit 7 rising edge only
// [RULE14] Program stop: bits 15,14 both clear
// [RULE15] Program resume: 15 clear, 14 set
// [RULE16] Program reset: 15 set, 14 clear
// [RULE17] Program start: bit 14 set
// [RULE18] Part program writes word as two bytes
// [RULE19] Fault event forces fault reaction active state
// [RULE20] Switched on holds; tracking only when enabled
// [RULE21] Disable voltage beats quick stop beats others
// [RULE22] Illegal transitions ignored, state unchanged
`ifndef ACWD_DEFINES_VH
`define ACWD_DEFINES_VH
`define ACWD_BIT_SWITCH_ON   0
`define ACWD_BIT_VOLT        1
`define ACWD_BIT_QSTOP       2
`define ACWD_BIT_ENABLE      3
`define ACWD_BIT_MODE0       4
`define ACWD_BIT_MODE1       5
`define ACWD_BIT_MODE2       6
`define ACWD_BIT_FRESET      7
`define ACWD_BIT_RUN         14
`define ACWD_BIT_CLEAR       15
`define ACWD_WORD_RESET      16'h0000
`define ACWD_MODE_OTHER      3'h0
`define ACWD_MODE_PROFILE    3'h1
`define ACWD_MODE_HOMING     3'h2
`define ACWD_MODE_GEARING    3'h3
`define ACWD_MODE_INTERP     3'h4
`endif

// File: acwd_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
module acwd_decoder_properties (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // Writers
    input wire logic        bus_wr,
    input wire logic [15:0] bus_wdata,
    input wire logic        prog_lo_wr,
    input wire logic        prog_hi_wr,
    input wire logic [7:0]  prog_lo_data,
    // Stored word and decodes
    input wire logic [15:0] axis_command_word,
    input wire logic        cmd_shutdown,
    input wire logic        cmd_enable_op,
    input wire logic        cmd_quick_stop,
    input wire logic        cmd_disable_volt,
    input wire logic        cmd_fault_reset,
    input wire logic        prog_stop,
    input wire logic        program_run_request
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    sequence s_bus_only;
        bus_wr && !prog_lo_wr && !prog_hi_wr;
    endsequence
    sequence s_bit7_rise;
        !axis_command_word[7] ##1 axis_command_word[7];
    endsequence
    property p_bus_word;
        s_bus_only |=> axis_command_word == $past(bus_wdata);
    endproperty
    property p_lo_byte;
        prog_lo_wr |=> axis_command_word[7:0] == $past(prog_lo_data);
    endproperty
    property p_shutdown;
        $past(rst_b) |-> cmd_shutdown == ($past(axis_command_word[2:0]) == 3'h6);
    endproperty
    property p_enable_op;
        $past(rst_b) |-> cmd_enable_op == ($past(axis_command_word[3:0]) == 4'hf);
    endproperty
    property p_quick_stop;
        $past(rst_b) |-> cmd_quick_stop == ($past(axis_command_word[2:1]) == 2'h1);
    endproperty
    property p_disable_volt;
        $past(rst_b) |-> cmd_disable_volt == !$past(axis_command_word[1]);
    endproperty
    // Pulse once on the edge, then low on the next cycle while bit 7 stays high
    property p_fault_pulse;
        s_bit7_rise |=> cmd_fault_reset ##1 !cmd_fault_reset;
    endproperty
    property p_prog_stop;
        $past(rst_b) |-> prog_stop == ($past(axis_command_word[15:14]) == 2'h0);
    endproperty
    property p_run;
        $past(rst_b) |-> program_run_request == $past(axis_command_word[14]);
    endproperty
    a_bus_word: assert property (p_bus_word) else $error("bus word not stored");
    a_lo_byte: assert property (p_lo_byte) else $error("low byte not stored");
    a_shutdown: assert property (p_shutdown) else $error("shutdown decode");
    a_enable_op: assert property (p_enable_op) else $error("enable decode");
    a_quick_stop: assert property (p_quick_stop) else $error("quick stop decode");
    a_disable_volt: assert property (p_disable_volt) else $error("volt decode");
    a_fault_pulse: assert property (p_fault_pulse) else $error("fault reset pulse");
    a_prog_stop: assert property (p_prog_stop) else $error("program stop decode");
    a_run: assert property (p_run) else $error("program run decode");
endmodule
`default_nettype wire

// File: acwd_writer.sv
`timescale 1ns/1ps
`default_nettype none
module acwd_writer (
    input  wire logic        clk,
    output var  logic        bus_wr,
    output var  logic [15:0] bus_wdata,
    output var  logic        lo_wr,
    output var  logic        hi_wr,
    output var  logic [7:0]  lo_data,
    output var  logic [7:0]  hi_data
);
    initial {bus_wr, lo_wr, hi_wr, bus_wdata, lo_data, hi_data} = 35'h0;
    // Data scrambled once released so stale values never look valid
    task put(input logic [15:0] w, input logic bytes);
        @(posedge clk);
        if (bytes) {lo_wr, hi_wr, hi_data, lo_data} <= {2'h3, w};
        else {bus_wr, bus_wdata} <= {1'b1, w};
        @(posedge clk);
        {bus_wr, lo_wr, hi_wr} <= 3'h0;
        {bus_wdata, hi_data, lo_data} <= {~w, ~w};
    endtask
endmodule
`default_nettype wire

// File: test_acwd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_acwd_decoder;
    logic core_clk = 1'b0, rst_b = 1'b0, fault_event = 1'b0, init_done = 1'b0;
    logic [2:0] op_mode = 3'h0;
    logic bus_wr, lo_wr, hi_wr, power_en, track_en, run, clr, stop, resume;
    logic [15:0] bus_wdata, word;
    logic [7:0] lo_data, hi_data;
    logic [6:0] state, cmd;
    logic [5:0] mode;
    int errors = 0;
    int check_count = 0;
    always #25 core_clk = ~core_clk;
    acwd_writer m (.clk(core_clk), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .lo_wr(lo_wr),
        .hi_wr(hi_wr), .lo_data(lo_data), .hi_data(hi_data));
    acwd_decoder dut (.core_clk(core_clk), .rst_b(rst_b), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
        .prog_lo_wr(lo_wr), .prog_lo_data(lo_data), .prog_hi_wr(hi_wr), .prog_hi_data(hi_data),
        .op_mode(op_mode), .fault_event(fault_event), .fault_reaction_done(1'b0),
        .init_done(init_done), .stop_done(1'b0), .axis_command_word(word), .axis_state(state),
        .power_stage_en(power_en), .setpoint_track_en(track_en), .cmd_shutdown(cmd[6]),
        .cmd_switch_on(cmd[5]), .cmd_enable_op(cmd[4]), .cmd_disable_op(cmd[3]),
        .cmd_quick_stop(cmd[2]), .cmd_disable_volt(cmd[1]), .cmd_fault_reset(cmd[0]),
        .pp_new_setpoint(mode[5]), .pp_change_now(mode[4]), .pp_relative(mode[3]),
        .homing_start(mode[2]), .gear_sync(mode[1]), .interp_enable(mode[0]),
        .program_run_request(run), .program_clear_request(clr), .prog_stop(stop),
        .prog_resume(resume));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Decodes land one edge after the word edge; fault reset pulse lasts one cycle
    task automatic put(input logic [15:0] w, input logic bytes);
        m.put(w, bytes);
        @(posedge core_clk);
        #1;
    endtask
    task automatic t_axis;
        logic [15:0] ws [10] = '{16'h0006, 16'h0007, 16'h0087, 16'h008f, 16'h000e,
            16'h0085, 16'h000b, 16'h0002, 16'h0000, 16'h000f};
        logic p7;
        p7 = 1'b0;
        foreach (ws[i]) begin
            put(ws[i], i[0]);
            chk(cmd, {ws[i][2:0] == 3'h6, ws[i][2:0] == 3'h7, ws[i][3:0] == 4'hf,
                ws[i][3:0] == 4'h7, ws[i][2:1] == 2'h1, !ws[i][1], ws[i][7] && !p7});
            p7 = ws[i][7];
        end
    endtask
    task automatic t_prog;
        for (int i = 0; i < 4; i++) begin
            put({i[1:0], 14'h0006}, 1'b1);
            chk({run, clr, stop, resume}, {i[0], i[1:0] == 2'h2, i[1:0] == 2'h0, i[1:0] == 2'h1});
        end
    endtask
    task automatic t_mode;
        logic [5:0] ex [6] = '{6'h00, 6'h38, 6'h04, 6'h02, 6'h01, 6'h30};
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            op_mode <= (i == 5) ? 3'h1 : i[2:0];
            put((i == 5) ? 16'h0070 : 16'h0030, 1'b0);
            chk(mode, ex[i]);
        end
    endtask
    task automatic t_state;
        @(posedge core_clk);
        init_done <= 1'b1;
        put(16'h0000, 1'b0);
        put(16'h0007, 1'b0);
        chk(state, 7'h02);
        put(16'h0006, 1'b0);
        put(16'h0007, 1'b0);
        chk({state, power_en, track_en}, {7'h08, 2'h2});
        put(16'h000f, 1'b0);
        chk({state, track_en}, {7'h10, 1'b1});
        fault_event <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk(state, 7'h40);
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1;
        chk({word, 9'h0, state}, {16'h0000, 16'h0001});
        t_axis();
        t_prog();
        t_mode();
        t_state();
        tally_and_finish();
    end
endmodule
bind acwd_decoder acwd_decoder_properties chk_i (.core_clk(core_clk), .rst_b(rst_b),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .prog_lo_wr(prog_lo_wr), .prog_hi_wr(prog_hi_wr),
    .prog_lo_data(prog_lo_data), .axis_command_word(axis_command_word),
    .cmd_shutdown(cmd_shutdown), .cmd_enable_op(cmd_enable_op), .cmd_quick_stop(cmd_quick_stop),
    .cmd_disable_volt(cmd_disable_volt), .cmd_fault_reset(cmd_fault_reset),
    .prog_stop(prog_stop), .program_run_request(program_run_request));
`default_nettype wire
